// >>> inc/pcs_pkg.sv
/*
 * Shared constants and carrier types of the program-counter, return-stack and
 * indirect-address block. Assumes one core clock and a synchronous reset.
 */
package pcs_pkg;

   // -----------------------------------------------------------------------
   // Register map (byte addresses on the register bus)
   // -----------------------------------------------------------------------
   localparam logic [11:0] STACK_INDEX_IDX = 12'hFED;
   localparam logic [11:0] TOP_ENTRY_LOW_IDX = 12'hFEE;
   localparam logic [11:0] TOP_ENTRY_HIGH_IDX = 12'hFEF;
   localparam logic [13:0] STACK_INDEX_ADDR = {STACK_INDEX_IDX, 2'b00};
   localparam logic [13:0] TOP_ENTRY_LOW_ADDR = {TOP_ENTRY_LOW_IDX, 2'b00};
   localparam logic [13:0] TOP_ENTRY_HIGH_ADDR = {TOP_ENTRY_HIGH_IDX, 2'b00};
   localparam logic [13:0] COUNTER_LOW_ADDR = 14'h0000;
   localparam logic [13:0] COUNTER_HOLD_ADDR = 14'h0004;
   localparam logic [13:0] COUNTER_FULL_ADDR = 14'h0008;
   localparam logic [13:0] CONTROL_ADDR = 14'h000C;
   localparam logic [13:0] FLAGS_ADDR = 14'h0010;

   // -----------------------------------------------------------------------
   // Reset values and field positions
   // -----------------------------------------------------------------------
   localparam logic [4:0] STACK_INDEX_RST = 5'h1F;
   localparam logic [14:0] PC_RST = 15'h0000;
   localparam int FLAG_OVER_BIT = 0;
   localparam int FLAG_UNDER_BIT = 1;
   localparam int CTRL_FAULT_RESET_BIT = 0;

   // -----------------------------------------------------------------------
   // Indirect address regions
   // -----------------------------------------------------------------------
   localparam logic [15:0] TRAD_LAST = 16'h0FFF;
   localparam logic [15:0] LINEAR_FIRST = 16'h2000;
   localparam logic [15:0] LINEAR_LAST = 16'h29AF;
   localparam logic [7:0] GPR_BLOCK_BYTES = 8'h50;
   localparam logic [7:0] GPR_BLOCK_BASE = 8'h20;
   localparam logic [6:0] WINDOW0_ADDR = 7'h00;
   localparam logic [6:0] WINDOW1_ADDR = 7'h01;
   localparam logic [1:0] FLASH_EXTRA_CYCLES = 2'h1;

   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PCS_OP_NONE, PCS_OP_WRITE_LOW, PCS_OP_CALL, PCS_OP_COMP_CALL,
      PCS_OP_JUMP_WORKING, PCS_OP_REL_JUMP, PCS_OP_RETURN, PCS_OP_VECTOR
   } pcs_op_e;

   typedef struct packed {
      logic valid;
      pcs_op_e op;
      logic [10:0] operand;
      logic [7:0] working;
      logic [14:0] vector;
   } pcs_cmd_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pcs_ind_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [11:0] addr;
      logic [7:0] wdata;
   } pcs_mem_req_s;

   typedef struct packed {
      logic valid;
      logic [14:0] addr;
   } pcs_flash_req_s;

endpackage

// >>> core/pcs_core.sv
/*
 * Program counter, 16-entry return stack and indirect-address decoder.
 * Assumes the execution core issues one command per fetch and that the data
 * memory and program flash answer reads combinationally in the same cycle.
 */
// Register access over AXI4-Lite was left to the implementer.
//
// Operation
// - Counter is 15 bits; low byte readable and writable, top seven from holding register.
// - Every reset clears the whole program counter.
// - Writing the low byte loads counter bits 14..8 from the holding register.
// - Direct call: operand gives bits 10..0, holding bits 6..3 give bits 14..11.
// - Computed call: low byte from working value, upper bits from holding register.
// - Branch-by-working loads counter plus one plus unsigned working value.
// - Relative branch loads counter plus one plus signed operand bits 8..0.
// - Return stack has sixteen fifteen-bit entries outside memory spaces.
// - Calls and vectoring push; returns pop; holding register untouched.
// - Without fault reset option the stack wraps circularly.
// - Overflow and underflow flags set regardless of fault reset option.
// - With fault reset option, overflow or underflow requests a device reset.
// - Stack index is five bits and always readable.
// - Top entry registers access the entry selected by stack index.
// - Push increments index then stores; pop reads entry then decrements.
// - Window access reaches pointer address; self-addressing reads zero, drops writes.
// - Pointer is sixteen bits split into data, linear and flash regions.
// - Pointer 0x000..0xFFF maps straight onto banked data addresses.
// - Pointer 0x2000..0x29AF maps onto 80-byte bank blocks; unmapped reads zero.
// - Pointer top bit set reads flash low byte; writes have no effect.
// - Flash access through a pointer takes one extra cycle.
module pcs_core #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire pcs_pkg::pcs_cmd_s cmd,
   input wire logic [6:0] counter_upper_holding,
   input wire logic [7:0] counter_low_wdata,
   input wire pcs_pkg::pcs_ind_req_s ind_req,
   output logic [7:0] ind_rdata,
   output logic ind_busy,
   output pcs_pkg::pcs_mem_req_s mem_req,
   input wire logic [7:0] mem_rdata,
   output pcs_pkg::pcs_flash_req_s flash_req,
   input wire logic [13:0] flash_rdata,
   output logic [14:0] pc_q,
   output logic stack_fault_reset_req,
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   logic [14:0] stack_q [STACK_DEPTH];
   logic [4:0] stack_index_q;
   logic stack_over_flag_q;
   logic stack_under_flag_q;
   logic stack_fault_reset_option_q;
   logic fault_req_q;
   logic [14:0] pc_d;
   logic [14:0] pc_inc;
   logic push;
   logic pop;
   logic [4:0] push_index;
   logic [3:0] slot_sel;
   logic aw_hold_q;
   logic w_hold_q;
   logic [13:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;
   logic flash_wait_q;

   // -----------------------------------------------------------------------
   // Program counter
   // -----------------------------------------------------------------------
   assign pc_inc = pc_q + 15'h0001;

   always_comb begin
      pc_d = pc_inc;
      if (cmd.valid) begin
         unique case (cmd.op)
            pcs_pkg::PCS_OP_NONE: pc_d = pc_inc;
            pcs_pkg::PCS_OP_WRITE_LOW: pc_d = {counter_upper_holding, counter_low_wdata};
            pcs_pkg::PCS_OP_CALL: pc_d = {counter_upper_holding[6:3], cmd.operand};
            pcs_pkg::PCS_OP_COMP_CALL: pc_d = {counter_upper_holding, cmd.working};
            pcs_pkg::PCS_OP_JUMP_WORKING: pc_d = pc_inc + {7'h00, cmd.working};
            pcs_pkg::PCS_OP_REL_JUMP: begin
               pc_d = pc_inc + {{6{cmd.operand[8]}}, cmd.operand[8:0]};
            end
            pcs_pkg::PCS_OP_RETURN: pc_d = stack_q[stack_index_q[3:0]];
            pcs_pkg::PCS_OP_VECTOR: pc_d = cmd.vector;
         endcase
      end
   end

   // The 15-bit counter; all bits are exposed on pc_q and through the full-counter register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_q <= pkg_pc_rst();
      end else if (!ind_busy) begin
         pc_q <= pc_d;
      end
   end

   function automatic logic [14:0] pkg_pc_rst();
      return pcs_pkg::PC_RST;
   endfunction

   // -----------------------------------------------------------------------
   // Return stack
   // -----------------------------------------------------------------------
   assign push = cmd.valid && !ind_busy && (cmd.op == pcs_pkg::PCS_OP_CALL
      || cmd.op == pcs_pkg::PCS_OP_COMP_CALL || cmd.op == pcs_pkg::PCS_OP_VECTOR);
   assign pop = cmd.valid && !ind_busy && cmd.op == pcs_pkg::PCS_OP_RETURN;
   assign push_index = stack_index_q + 5'h01;
   assign slot_sel = wr_go ? stack_index_q[3:0] : push_index[3:0];

   // Stack index: the fifth bit lets a full or empty stack be told apart.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_index_q <= pcs_pkg::STACK_INDEX_RST;
      end else if (push) begin
         stack_index_q <= (push_index == 5'h10) ? 5'h00 : push_index;
      end else if (pop) begin
         stack_index_q <= stack_index_q - 5'h01;
      end else if (wr_go && wr_hit && awaddr_q == pcs_pkg::STACK_INDEX_ADDR && wstrb_q[0]) begin
         stack_index_q <= wdata_q[4:0];
      end
   end

   // Entries are stored with the slot number modulo the depth, so pushes wrap.
   always_ff @(posedge aclk) begin
      if (push) begin
         stack_q[push_index[3:0]] <= pc_q;
      end else if (wr_go && wr_hit && wstrb_q[0]) begin
         if (awaddr_q == pcs_pkg::TOP_ENTRY_LOW_ADDR) begin
            stack_q[slot_sel][7:0] <= wdata_q[7:0];
         end else if (awaddr_q == pcs_pkg::TOP_ENTRY_HIGH_ADDR) begin
            stack_q[slot_sel][14:8] <= wdata_q[6:0];
         end
      end
   end

   // Flags are sticky; a hardware set wins over a software clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_over_flag_q <= 1'b0;
         stack_under_flag_q <= 1'b0;
      end else begin
         if (push && stack_index_q == 5'h0F) begin
            stack_over_flag_q <= 1'b1;
         end else if (wr_go && awaddr_q == pcs_pkg::FLAGS_ADDR && wstrb_q[0]
                      && wdata_q[pcs_pkg::FLAG_OVER_BIT]) begin
            stack_over_flag_q <= 1'b0;
         end
         if (pop && stack_index_q == 5'h1F) begin
            stack_under_flag_q <= 1'b1;
         end else if (wr_go && awaddr_q == pcs_pkg::FLAGS_ADDR && wstrb_q[0]
                      && wdata_q[pcs_pkg::FLAG_UNDER_BIT]) begin
            stack_under_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stack_fault_reset_option_q <= 1'b0;
      end else if (wr_go && awaddr_q == pcs_pkg::CONTROL_ADDR && wstrb_q[0]) begin
         stack_fault_reset_option_q <= wdata_q[pcs_pkg::CTRL_FAULT_RESET_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_req_q <= 1'b0;
      end else begin
         fault_req_q <= stack_fault_reset_option_q && ((push && stack_index_q == 5'h0F)
            || (pop && stack_index_q == 5'h1F));
      end
   end
   assign stack_fault_reset_req = fault_req_q;

   // -----------------------------------------------------------------------
   // Indirect addressing
   // -----------------------------------------------------------------------
   logic [15:0] lin_off;
   logic [11:0] lin_bank;
   logic [6:0] lin_byte;
   logic in_trad;
   logic in_lin;
   logic in_flash;
   logic self_ref;

   assign in_flash = ind_req.addr[15];
   assign in_trad = !in_flash && ind_req.addr <= pcs_pkg::TRAD_LAST;
   assign in_lin = ind_req.addr >= pcs_pkg::LINEAR_FIRST
      && ind_req.addr <= pcs_pkg::LINEAR_LAST;
   assign lin_off = ind_req.addr - pcs_pkg::LINEAR_FIRST;
   assign lin_bank = 12'(lin_off / {8'h00, pcs_pkg::GPR_BLOCK_BYTES});
   assign lin_byte = 7'(lin_off % {8'h00, pcs_pkg::GPR_BLOCK_BYTES});
   assign self_ref = in_trad && (ind_req.addr[6:0] == pcs_pkg::WINDOW0_ADDR
      || ind_req.addr[6:0] == pcs_pkg::WINDOW1_ADDR);

   always_comb begin
      mem_req = '0;
      if (ind_req.valid && !self_ref) begin
         if (in_trad) begin
            mem_req.valid = 1'b1;
            mem_req.write = ind_req.write;
            mem_req.addr = ind_req.addr[11:0];
            mem_req.wdata = ind_req.wdata;
         end else if (in_lin) begin
            mem_req.valid = 1'b1;
            mem_req.write = ind_req.write;
            mem_req.addr = {lin_bank[4:0], pcs_pkg::GPR_BLOCK_BASE[6:0]
               + lin_byte};
            mem_req.wdata = ind_req.wdata;
         end
      end
   end

   assign flash_req.valid = ind_req.valid && in_flash && !ind_req.write;
   assign flash_req.addr = ind_req.addr[14:0];

   always_comb begin
      ind_rdata = 8'h00;
      if (ind_req.valid && !ind_req.write && !self_ref) begin
         if (in_flash) begin
            ind_rdata = flash_rdata[7:0];
         end else if (in_trad || in_lin) begin
            ind_rdata = mem_rdata;
         end
      end
   end

   // A flash access holds the core for one extra cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_wait_q <= 1'b0;
      end else begin
         flash_wait_q <= ind_req.valid && in_flash && !flash_wait_q;
      end
   end
   assign ind_busy = ind_req.valid && in_flash && !flash_wait_q;

   // -----------------------------------------------------------------------
   // Register bus slave
   // -----------------------------------------------------------------------
   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
   assign wr_go = aw_hold_q && w_hold_q;
   assign wr_hit = awaddr_q == pcs_pkg::STACK_INDEX_ADDR
      || awaddr_q == pcs_pkg::TOP_ENTRY_LOW_ADDR
      || awaddr_q == pcs_pkg::TOP_ENTRY_HIGH_ADDR
      || awaddr_q == pcs_pkg::CONTROL_ADDR || awaddr_q == pcs_pkg::FLAGS_ADDR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pcs_pkg::AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[13:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? pcs_pkg::AXI_OKAY : pcs_pkg::AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_hit = 1'b1;
      unique case ({s_axi_araddr[13:2], 2'b00})
         pcs_pkg::STACK_INDEX_ADDR: rd_word = {27'h0, stack_index_q};
         pcs_pkg::TOP_ENTRY_LOW_ADDR: rd_word = {24'h0, stack_q[stack_index_q[3:0]][7:0]};
         pcs_pkg::TOP_ENTRY_HIGH_ADDR: rd_word = {25'h0, stack_q[stack_index_q[3:0]][14:8]};
         pcs_pkg::COUNTER_LOW_ADDR: rd_word = {24'h0, pc_q[7:0]};
         pcs_pkg::COUNTER_HOLD_ADDR: rd_word = {25'h0, counter_upper_holding};
         pcs_pkg::COUNTER_FULL_ADDR: rd_word = {17'h0, pc_q};
         pcs_pkg::CONTROL_ADDR: rd_word = {31'h0, stack_fault_reset_option_q};
         pcs_pkg::FLAGS_ADDR: rd_word = {30'h0, stack_under_flag_q, stack_over_flag_q};
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= pcs_pkg::AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? pcs_pkg::AXI_OKAY : pcs_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------
   property p_reset_clears_pc;
      @(posedge aclk) !aresetn |=> pc_q == 15'h0000;
   endproperty
   a_reset_clears_pc: assert property (p_reset_clears_pc) else $error("pc not cleared");

   property p_write_low;
      @(posedge aclk) disable iff (!aresetn)
      cmd.valid && cmd.op == pcs_pkg::PCS_OP_WRITE_LOW && !ind_busy
      |=> pc_q == {$past(counter_upper_holding), $past(counter_low_wdata)};
   endproperty
   a_write_low: assert property (p_write_low) else $error("low write load wrong");

   property p_call;
      @(posedge aclk) disable iff (!aresetn)
      cmd.valid && cmd.op == pcs_pkg::PCS_OP_CALL && !ind_busy
      |=> pc_q == {$past(counter_upper_holding[6:3]), $past(cmd.operand)}
          && stack_q[stack_index_q[3:0]] == $past(pc_q);
   endproperty
   a_call: assert property (p_call) else $error("call load or push wrong");

   property p_jump_working;
      @(posedge aclk) disable iff (!aresetn)
      cmd.valid && cmd.op == pcs_pkg::PCS_OP_JUMP_WORKING && !ind_busy
      |=> pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(cmd.working)});
   endproperty
   a_jump_working: assert property (p_jump_working) else $error("working jump wrong");

   property p_return;
      @(posedge aclk) disable iff (!aresetn)
      pop |=> stack_index_q == $past(stack_index_q) - 5'h01;
   endproperty
   a_return: assert property (p_return) else $error("pop index wrong");

   property p_advance;
      @(posedge aclk) disable iff (!aresetn)
      !cmd.valid && !ind_busy ##1 !cmd.valid && !ind_busy
      |=> pc_q == 15'($past(pc_q, 2) + 15'h0002);
   endproperty
   a_advance: assert property (p_advance) else $error("pc not advancing");

   property p_over_flag;
      @(posedge aclk) disable iff (!aresetn)
      push && stack_index_q == 5'h0F |=> stack_over_flag_q && stack_index_q == 5'h00;
   endproperty
   a_over_flag: assert property (p_over_flag) else $error("overflow not flagged");

   property p_fault_reset;
      @(posedge aclk) disable iff (!aresetn)
      stack_fault_reset_option_q && pop && stack_index_q == 5'h1F |=> stack_fault_reset_req;
   endproperty
   a_fault_reset: assert property (p_fault_reset) else $error("no fault reset");

   property p_flash_stall;
      @(posedge aclk) disable iff (!aresetn)
      ind_req.valid && in_flash && !flash_wait_q |-> ind_busy ##1 !ind_busy;
   endproperty
   a_flash_stall: assert property (p_flash_stall) else $error("flash stall wrong");

   property p_self_zero;
      @(posedge aclk) disable iff (!aresetn)
      ind_req.valid && self_ref |-> ind_rdata == 8'h00 && !mem_req.valid;
   endproperty
   a_self_zero: assert property (p_self_zero) else $error("window self access leaked");

endmodule

// >>> tb/pcs_far_model.sv
/*
 * Far-side model: data memory and program flash that answer the block.
 * Assumes requests are combinational and writes land at the rising edge.
 */
module pcs_far_model (
   input wire logic aclk,
   input wire pcs_pkg::pcs_mem_req_s mem_req,
   output logic [7:0] mem_rdata,
   input wire pcs_pkg::pcs_flash_req_s flash_req,
   output logic [13:0] flash_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ram [4096];
   logic [7:0] mem_last_q;
   logic [13:0] flash_last_q;
   initial begin
      foreach (ram[i]) ram[i] = 8'hEE;
   end
   always @(posedge aclk) begin
      if (mem_req.valid === 1'b1 && mem_req.write === 1'b1) begin
         ram[mem_req.addr] <= mem_req.wdata;
      end
      mem_last_q <= mem_rdata;
      flash_last_q <= flash_rdata;
   end
   // Idle ports show the inverse of the last value, so stale data is never trusted.
   assign mem_rdata = mem_req.valid ? ram[mem_req.addr] : ~mem_last_q;
   assign flash_rdata = flash_req.valid ? {flash_req.addr[13:8] ^ 6'h2A,
      flash_req.addr[7:0] ^ 8'hC3} : ~flash_last_q;
endmodule

// >>> tb/pcs_core_test.sv
/*
 * Self-checking bench of the counter, return stack and indirect decoder.
 * Assumes the far-side model answers memory and flash in the same cycle.
 */
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pcs_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, ind_busy, stack_fault_reset_req;
   pcs_pkg::pcs_cmd_s cmd;
   pcs_pkg::pcs_ind_req_s ind_req;
   pcs_pkg::pcs_mem_req_s mem_req;
   pcs_pkg::pcs_flash_req_s flash_req;
   logic [6:0] counter_upper_holding;
   logic [7:0] counter_low_wdata, ind_rdata, mem_rdata;
   logic [13:0] flash_rdata, s_axi_awaddr, s_axi_araddr;
   logic [14:0] pc_q;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int fail_count, checks, pulses;
   pcs_core pcs_core_i (.aclk, .aresetn, .cmd, .counter_upper_holding, .counter_low_wdata,
      .ind_req, .ind_rdata, .ind_busy, .mem_req, .mem_rdata, .flash_req, .flash_rdata, .pc_q,
      .stack_fault_reset_req, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   pcs_far_model pcs_far_model_i (.aclk, .mem_req, .mem_rdata, .flash_req, .flash_rdata);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (stack_fault_reset_req === 1'b1) pulses <= pulses + 1;
   end
   // ---------------------------------------------------------------
   // Bus and command tasks
   // ---------------------------------------------------------------
   task automatic axi_wr(logic [13:0] a, logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(logic [13:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic step(pcs_pkg::pcs_op_e o, logic [10:0] opd, logic [7:0] w);
      cmd <= '{valid: 1'b1, op: o, operand: opd, working: w, vector: 15'h1234};
      @(posedge aclk);
      cmd.valid <= 1'b0;
      #1;
   endtask
   task automatic load(logic [6:0] h, logic [7:0] l);
      counter_upper_holding <= h;
      counter_low_wdata <= l;
      step(pcs_pkg::PCS_OP_WRITE_LOW, 11'h000, 8'h00);
   endtask
   task automatic ind_go(logic w, logic [15:0] a, logic [7:0] d);
      @(posedge aclk);
      ind_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
      #1;
   endtask
   task automatic ind_end;
      @(posedge aclk);
      ind_req.valid <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      `CHK(pc_q, 15'h0000)
      axi_rd(pcs_pkg::STACK_INDEX_ADDR);
      `CHK(rd, 32'h0000001F)
      axi_rd(14'h0100);
      `CHK({rr, rd}, {pcs_pkg::AXI_SLVERR, 32'h00000000})
   endtask
   task automatic t_loads;
      load(7'h55, 8'hA3);
      `CHK(pc_q, 15'h55A3)
      axi_rd(pcs_pkg::COUNTER_LOW_ADDR);
      `CHK(rd, 32'h000000A4)
      load(7'h7F, 8'hFF);
      step(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h00);
      `CHK(pc_q, 15'h0000)
      load(7'h7F, 8'h80);
      step(pcs_pkg::PCS_OP_JUMP_WORKING, 11'h000, 8'hFF);
      `CHK(pc_q, 15'h0080)
      load(7'h01, 8'h00);
      step(pcs_pkg::PCS_OP_REL_JUMP, 11'h7F0, 8'h00);
      `CHK(pc_q, 15'h00F1)
   endtask
   task automatic t_stack;
      load(7'h78, 8'h42);
      step(pcs_pkg::PCS_OP_CALL, 11'h5A5, 8'h00);
      `CHK(pc_q, 15'h7DA5)
      step(pcs_pkg::PCS_OP_COMP_CALL, 11'h000, 8'h3C);
      `CHK(pc_q, 15'h783C)
      step(pcs_pkg::PCS_OP_VECTOR, 11'h000, 8'h00);
      `CHK(pc_q, 15'h1234)
      axi_rd(pcs_pkg::STACK_INDEX_ADDR);
      `CHK(rd, 32'h00000002)
      axi_rd(pcs_pkg::TOP_ENTRY_HIGH_ADDR);
      `CHK(rd, 32'h00000078)
      step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
      step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
      `CHK(pc_q, 15'h7DA5)
      step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
      `CHK(pc_q, 15'h7842)
      axi_wr(pcs_pkg::STACK_INDEX_ADDR, 32'h5);
      axi_wr(pcs_pkg::TOP_ENTRY_LOW_ADDR, 32'h11);
      axi_wr(pcs_pkg::TOP_ENTRY_HIGH_ADDR, 32'h22);
      `CHK(rr, pcs_pkg::AXI_OKAY)
      step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
      `CHK(pc_q, 15'h2211)
      axi_rd(pcs_pkg::STACK_INDEX_ADDR);
      `CHK(rd, 32'h00000004)
   endtask
   task automatic t_faults;
      axi_wr(pcs_pkg::STACK_INDEX_ADDR, 32'h1F);
      for (int i = 0; i < 17; i++) step(pcs_pkg::PCS_OP_CALL, 11'(i), 8'h00);
      axi_rd(pcs_pkg::TOP_ENTRY_LOW_ADDR);
      `CHK(rd, 32'h0000000F)
      axi_rd(pcs_pkg::FLAGS_ADDR);
      `CHK({rd, pulses}, {32'h00000001, 32'd0})
      axi_wr(pcs_pkg::FLAGS_ADDR, 32'h3);
      axi_wr(pcs_pkg::CONTROL_ADDR, 32'h1);
      axi_wr(pcs_pkg::STACK_INDEX_ADDR, 32'h1F);
      step(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h00);
      repeat (2) @(posedge aclk);
      axi_rd(pcs_pkg::FLAGS_ADDR);
      `CHK({rd, pulses}, {32'h00000002, 32'd1})
   endtask
   task automatic t_indirect;
      ind_go(1'b1, 16'h00A1, 8'h77);
      ind_end;
      ind_go(1'b0, 16'h2051, 8'h00);
      `CHK({mem_req.addr, ind_rdata}, {12'h0A1, 8'h77})
      ind_go(1'b0, 16'h00A1, 8'h00);
      `CHK(ind_rdata, 8'h77)
      ind_go(1'b0, 16'h1000, 8'h00);
      `CHK(ind_rdata, 8'h00)
      ind_go(1'b1, 16'h0100, 8'h99);
      ind_end;
      `CHK(pcs_far_model_i.ram[12'h100], 8'hEE)
      ind_go(1'b0, 16'h0181, 8'h00);
      `CHK(ind_rdata, 8'h00)
      ind_go(1'b0, 16'h8123, 8'h00);
      `CHK(ind_busy, 1'b1)
      @(posedge aclk);
      #1;
      `CHK({ind_busy, flash_req.addr, ind_rdata}, {1'b0, 15'h0123, 8'hE0})
      ind_end;
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      aresetn = 1'b0;
      cmd = '0;
      ind_req = '0;
      counter_upper_holding = 7'h00;
      counter_low_wdata = 8'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      t_reset;
      t_loads;
      t_stack;
      t_faults;
      t_indirect;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      tally_and_finish;
   end
endmodule
